// file: rtl/display_idle_timeout_menu.v
/*
  display module idle logic: lcd sleep, auto-exit of setup pages, the two
  timeout setup pages, the home page status line and the cycle/hour counts.
  assumes raw buttons from pins (synchronised here), status inputs on mclk.
*/
`timescale 1ns/100ps
`include "idle_menu_map.vh"
// Contract
// - blank lcd after selected idle sleep period
// - inactivity choices none, 30s to 1h
// - auto-exit idle pages except home, lockout, diagnostics
// - any button press counts as activity
// - setup page shows stored setting on entry
// - up/down step choices on edit line
// - right/left move focus to save commands
// - up/down toggle accept and reject
// - ok stores on accept, discards on reject
// - after save command return to setup menu
// - home line shows user-selected status item
// - cycle count up on each valve energize
// - hour count up per 60 valve minutes
// - report last lockout reason code 0-127
// - terminal item shows each terminal on/off
module display_idle_timeout_menu #(
  parameter TICK_CYCLES = `ONE_SECOND_MS * `CLK_KHZ,
  parameter TERMS = 16
) (
  input wire mclk,
  input wire rst,
  input wire btn_up_raw,
  input wire btn_down_raw,
  input wire btn_left_raw,
  input wire btn_right_raw,
  input wire btn_ok_raw,
  input wire lockout_active,
  input wire diag_active,
  input wire main_valve_on,
  input wire [6:0] last_lockout_reason,
  input wire [TERMS-1:0] terminal_state,
  input wire [3:0] status_select,
  output reg lcd_on,
  output reg [4:0] page,
  output reg menu_cursor,
  output reg [2:0] edit_value,
  output reg focus_save,
  output reg save_accept,
  output reg [2:0] sleep_setting,
  output reg [2:0] inact_setting,
  output reg [3:0] status_line_item,
  output reg [16:0] status_line_value,
  output reg [TERMS-1:0] status_line_terms,
  output reg [16:0] cycle_count,
  output reg [16:0] hour_count
);
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  reg [4:0] btn_meta, btn_sync, btn_prev;
  reg [31:0] div_count;
  reg tick, valve_prev;
  reg [11:0] valve_seconds, sleep_limit, inact_limit;
  reg [4:0] next_page;
  reg next_menu_cursor, next_focus_save, next_save_accept;
  reg [2:0] next_edit_value, next_sleep_setting, next_inact_setting, choices;
  wire sleep_expired, inact_expired;

  // two-stage synchroniser, then edge detect on the second stage
  always @(posedge mclk)
  begin
    if (rst)
    begin
      btn_meta <= 5'h00;
      btn_sync <= 5'h00;
      btn_prev <= 5'h00;
    end
    else
    begin
      btn_meta <= {btn_ok_raw, btn_right_raw, btn_left_raw, btn_down_raw, btn_up_raw};
      btn_sync <= btn_meta;
      btn_prev <= btn_sync;
    end
  end

  // one-cycle press pulses; any of them is user activity
  wire [4:0] press = btn_sync & ~btn_prev;
  wire any_press = |press;
  wire p_up = press[0];
  wire p_down = press[1];
  wire p_left = press[2];
  wire p_right = press[3];
  wire p_ok = press[4];
  // gating the exit itself keeps presses working while diagnostics run
  wire auto_exit = inact_expired && !diag_active;

  // one-second enable from the clock divider
  always @(posedge mclk)
  begin
    if (rst)
    begin
      div_count <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else
    begin
      div_count <= (div_count == TICK_LAST) ? 32'h0000_0000 : div_count + 32'h0000_0001;
      tick <= (div_count == TICK_LAST);
    end
  end

  // setting code to seconds; zero means never / none
  always @*
  begin
    case (sleep_setting)
      3'h1: sleep_limit = `SLEEP_S1;
      3'h2: sleep_limit = `SLEEP_S2;
      3'h3: sleep_limit = `SLEEP_S3;
      3'h4: sleep_limit = `SLEEP_S4;
      3'h5: sleep_limit = `SLEEP_S5;
      3'h6: sleep_limit = `SLEEP_S6;
      default: sleep_limit = 12'h000;
    endcase
    case (inact_setting)
      3'h1: inact_limit = `INACT_S1;
      3'h2: inact_limit = `INACT_S2;
      3'h3: inact_limit = `INACT_S3;
      3'h4: inact_limit = `INACT_S4;
      3'h5: inact_limit = `INACT_S5;
      default: inact_limit = 12'h000;
    endcase
  end

  // idle timers restart on any press
  idle_timer #(.WIDTH(12)) sleep_timer (
    .mclk(mclk), .rst(rst), .tick(tick), .limit(sleep_limit), .expired(sleep_expired),
    .restart(any_press)
  );
  idle_timer #(.WIDTH(12)) inact_timer (
    .mclk(mclk), .rst(rst), .tick(tick), .limit(inact_limit), .expired(inact_expired),
    .restart(any_press)
  );

  // lcd blanks on sleep expiry, any press relights it
  always @(posedge mclk)
  begin
    if (rst)
      lcd_on <= 1'b1;
    else if (any_press)
      lcd_on <= 1'b1;
    else if (sleep_expired)
      lcd_on <= 1'b0;
  end

  // page navigation and timeout setup editing
  always @*
  begin
    next_page = page;
    next_menu_cursor = menu_cursor;
    next_edit_value = edit_value;
    next_focus_save = focus_save;
    next_save_accept = save_accept;
    next_sleep_setting = sleep_setting;
    next_inact_setting = inact_setting;
    choices = (page == `PAGE_SLEEP) ? `SLEEP_CHOICES : `INACT_CHOICES;
    case (page)
      `PAGE_HOME:
      begin
        if (lcd_on && p_ok)
        begin
          next_page = `PAGE_MENU;
          next_menu_cursor = 1'b0;
        end
      end
      `PAGE_MENU:
      begin
        if (auto_exit)
          next_page = `PAGE_HOME;
        else if (!lcd_on)
          next_page = page;
        else if (p_up || p_down)
          next_menu_cursor = ~menu_cursor;
        else if (p_left)
          next_page = `PAGE_HOME;
        else if (p_ok || p_right)
        begin
          next_page = menu_cursor ? `PAGE_INACT : `PAGE_SLEEP;
          next_edit_value = menu_cursor ? inact_setting : sleep_setting;
          next_focus_save = 1'b0;
          next_save_accept = 1'b1;
        end
      end
      `PAGE_SLEEP, `PAGE_INACT:
      begin
        if (auto_exit)
          next_page = `PAGE_HOME;
        else if (!lcd_on)
          next_page = page;
        else if (p_left || p_right)
          next_focus_save = ~focus_save;
        else if (!focus_save && p_up)
          next_edit_value = (edit_value == choices - 3'h1) ? 3'h0 : edit_value + 3'h1;
        else if (!focus_save && p_down)
          next_edit_value = (edit_value == 3'h0) ? choices - 3'h1 : edit_value - 3'h1;
        else if (focus_save && (p_up || p_down))
          next_save_accept = ~save_accept;
        else if (focus_save && p_ok)
        begin
          if (save_accept && page == `PAGE_SLEEP)
            next_sleep_setting = edit_value;
          if (save_accept && page == `PAGE_INACT)
            next_inact_setting = edit_value;
          next_page = `PAGE_MENU;
          next_focus_save = 1'b0;
        end
      end
      `PAGE_LOCKOUT: next_page = `PAGE_HOME; // held below while lockout stays
      default: next_page = `PAGE_HOME;
    endcase
    // lockout takes over the display and never auto-exits
    if (lockout_active)
      next_page = `PAGE_LOCKOUT;
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      page <= `PAGE_HOME;
      menu_cursor <= 1'b0;
      edit_value <= 3'h0;
      focus_save <= 1'b0;
      save_accept <= 1'b1;
      sleep_setting <= `SLEEP_RESET;
      inact_setting <= `INACT_RESET;
    end
    else
    begin
      page <= next_page;
      menu_cursor <= next_menu_cursor;
      edit_value <= next_edit_value;
      focus_save <= next_focus_save;
      save_accept <= next_save_accept;
      sleep_setting <= next_sleep_setting;
      inact_setting <= next_inact_setting;
    end
  end

  // cycle count on valve rising edge, hour count per 3600 valve seconds
  always @(posedge mclk)
  begin
    if (rst)
    begin
      valve_prev <= 1'b0;
      valve_seconds <= 12'h000;
      cycle_count <= 17'h00000;
      hour_count <= 17'h00000;
    end
    else
    begin
      valve_prev <= main_valve_on;
      if (main_valve_on && !valve_prev && cycle_count != `COUNT_MAX)
        cycle_count <= cycle_count + 17'h00001;
      if (main_valve_on && tick)
      begin
        if (valve_seconds == `SECONDS_PER_HOUR - 12'h001)
        begin
          valve_seconds <= 12'h000;
          if (hour_count != `COUNT_MAX)
            hour_count <= hour_count + 17'h00001;
        end
        else
          valve_seconds <= valve_seconds + 12'h001;
      end
    end
  end

  // home page status line: selected item and its value
  always @(posedge mclk)
  begin
    if (rst)
    begin
      status_line_item <= `ITEM_CYCLES;
      status_line_value <= 17'h00000;
      status_line_terms <= {TERMS{1'b0}};
    end
    else
    begin
      status_line_item <= status_select;
      status_line_terms <= (status_select == `ITEM_TERMS) ? terminal_state : {TERMS{1'b0}};
      case (status_select)
        `ITEM_CYCLES: status_line_value <= cycle_count;
        `ITEM_HOURS: status_line_value <= hour_count;
        `ITEM_FAULT: status_line_value <= {10'h000, last_lockout_reason};
        default: status_line_value <= 17'h00000;
      endcase
    end
  end
endmodule

// file: rtl/idle_menu_map.vh
/*
  constants for the display idle, timeout menu and status line block:
  setting codes, timeout seconds, page codes, status item codes, timing.
  assumes a single 40 MHz clock; included by bare name from rtl/.
*/
`ifndef IDLE_MENU_MAP_VH
`define IDLE_MENU_MAP_VH

// clock and timing
`define CLK_KHZ 32'h0000_9c40
`define ONE_SECOND_MS 32'h0000_03e8
`define SECONDS_PER_HOUR 12'he10
`define COUNT_MAX 17'h1869f

// sleep setting codes: 0 never, then 5 s .. 1 h
`define SLEEP_CHOICES 3'h7
`define SLEEP_S1 12'h005
`define SLEEP_S2 12'h00a
`define SLEEP_S3 12'h01e
`define SLEEP_S4 12'h03c
`define SLEEP_S5 12'h12c
`define SLEEP_S6 12'he10
`define SLEEP_RESET 3'h0

// inactivity setting codes: 0 none, then 30 s .. 1 h
`define INACT_CHOICES 3'h6
`define INACT_S1 12'h01e
`define INACT_S2 12'h03c
`define INACT_S3 12'h12c
`define INACT_S4 12'h708
`define INACT_S5 12'he10
`define INACT_RESET 3'h0

// one-hot pages
`define PAGE_HOME 5'h01
`define PAGE_MENU 5'h02
`define PAGE_SLEEP 5'h04
`define PAGE_INACT 5'h08
`define PAGE_LOCKOUT 5'h10

// status line items
`define ITEM_CYCLES 4'h0
`define ITEM_HOURS 4'h1
`define ITEM_FAULT 4'h2
`define ITEM_TERMS 4'h3

`endif

// file: rtl/idle_timer.v
/*
  seconds idle timer: counts one-second ticks since the last restart and
  flags expiry once the count reaches a nonzero limit; limit zero disables.
  assumes tick is a one-cycle enable on the same clock.
*/
`timescale 1ns/100ps
module idle_timer #(
  parameter WIDTH = 12
) (
  input wire mclk,
  input wire rst,
  input wire tick,
  input wire restart,
  input wire [WIDTH-1:0] limit,
  output reg expired
);
  reg [WIDTH-1:0] seconds;

  // count idle seconds, saturating at the limit
  always @(posedge mclk)
  begin
    if (rst || restart)
    begin
      seconds <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end
    else if (limit == {WIDTH{1'b0}})
    begin
      seconds <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end
    else if (seconds >= limit)
      expired <= 1'b1;
    else if (tick)
      seconds <= seconds + {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule

// file: dv/idle_menu_sva.sv
/* checker of the idle timeout menu block: port relations over time.
   assumes one mclk domain and the active-high synchronous rst. */
`timescale 1ns/100ps
`include "idle_menu_map.vh"
module idle_menu_sva #(parameter TERMS = 16) (
  input wire mclk,
  input wire rst,
  input wire lockout_active,
  input wire main_valve_on,
  input wire [6:0] last_lockout_reason,
  input wire [TERMS-1:0] terminal_state,
  input wire [3:0] status_select,
  input wire lcd_on,
  input wire [4:0] page,
  input wire [2:0] edit_value,
  input wire focus_save,
  input wire save_accept,
  input wire [2:0] sleep_setting,
  input wire [3:0] status_line_item,
  input wire [16:0] status_line_value,
  input wire [TERMS-1:0] status_line_terms,
  input wire [16:0] cycle_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycle count follows valve rises only
  property p_cyc_inc;
    $rose(main_valve_on) && cycle_count < 17'h1869f |=> cycle_count == $past(cycle_count) + 17'h1;
  endproperty
  a_cyc_inc: assert property (p_cyc_inc) else $error("cycle count missed a rise");
  property p_cyc_hold;
    !$rose(main_valve_on) |=> $stable(cycle_count);
  endproperty
  a_cyc_hold: assert property (p_cyc_hold) else $error("cycle count moved");
  property p_lock;
    lockout_active ##1 lockout_active |-> page == `PAGE_LOCKOUT;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout page left");
  property p_item;
    1'b1 |=> status_line_item == $past(status_select);
  endproperty
  a_item: assert property (p_item) else $error("status item wrong");
  property p_fault;
    status_select == `ITEM_FAULT |=> status_line_value == {10'h0, $past(last_lockout_reason)};
  endproperty
  a_fault: assert property (p_fault) else $error("lockout reason wrong");
  property p_terms;
    status_select == `ITEM_TERMS |=> status_line_terms == $past(terminal_state);
  endproperty
  a_terms: assert property (p_terms) else $error("terminal states wrong");
  property p_entry;
    page == `PAGE_SLEEP && $past(page) != `PAGE_SLEEP |-> edit_value == sleep_setting && !focus_save;
  endproperty
  a_entry: assert property (p_entry) else $error("entry value wrong");
  property p_store;
    $changed(sleep_setting) |-> $past(page) == `PAGE_SLEEP && $past(focus_save) && $past(save_accept)
      && sleep_setting == $past(edit_value);
  endproperty
  a_store: assert property (p_store) else $error("setting stored wrongly");
  property p_never;
    sleep_setting == `SLEEP_RESET |-> lcd_on;
  endproperty
  a_never: assert property (p_never) else $error("display dark with never");
endmodule
bind display_idle_timeout_menu idle_menu_sva #(.TERMS(TERMS)) chk_u (.mclk(mclk), .rst(rst),
  .lockout_active(lockout_active), .main_valve_on(main_valve_on), .last_lockout_reason(last_lockout_reason),
  .terminal_state(terminal_state), .status_select(status_select), .lcd_on(lcd_on), .page(page),
  .edit_value(edit_value), .focus_save(focus_save), .save_accept(save_accept), .sleep_setting(sleep_setting),
  .status_line_item(status_line_item), .status_line_value(status_line_value),
  .status_line_terms(status_line_terms), .cycle_count(cycle_count));

// file: dv/button_panel.sv
/* model of the push buttons and the burner status source.
   assumes mclk; changes every line just after a rising edge. */
`timescale 1ns/100ps
module button_panel (
  input wire mclk,
  output reg [4:0] btn,
  output reg lockout_active,
  output reg diag_active,
  output reg main_valve_on,
  output reg [6:0] last_lockout_reason,
  output reg [15:0] terminal_state
);
  // all released at time zero
  initial
  begin
    btn = 5'h0;
    lockout_active = 1'b0;
    diag_active = 1'b0;
    main_valve_on = 1'b0;
    last_lockout_reason = 7'h0;
    terminal_state = 16'h0;
  end
  // one press: held four edges, then low four edges
  task press(input integer i);
  begin
    @(posedge mclk);
    btn[i] <= 1'b1;
    repeat (4) @(posedge mclk);
    btn[i] <= 1'b0;
    repeat (4) @(posedge mclk);
  end
  endtask
endmodule

// file: dv/display_idle_timeout_menu_tb.sv
/* testbench of the idle timeout menu block.
   assumes button_panel drives buttons and status; tick of 4 cycles. */
`timescale 1ns/100ps
module display_idle_timeout_menu_tb;
  localparam up = 0, dn = 1, lt = 2, rt = 3, ok = 4;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] status_select = 4'h0;
  wire [4:0] btn, page;
  wire lockout_active, diag_active, main_valve_on, lcd_on, menu_cursor, focus_save, save_accept;
  wire [6:0] last_lockout_reason;
  wire [15:0] terminal_state, status_line_terms;
  wire [2:0] edit_value, sleep_setting, inact_setting;
  wire [3:0] status_line_item;
  wire [16:0] status_line_value, cycle_count, hour_count;
  integer err_total = 0;
  integer checks_done = 0;
  integer n, i;
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  button_panel pan (.mclk(mclk), .btn(btn), .lockout_active(lockout_active), .diag_active(diag_active),
    .main_valve_on(main_valve_on), .last_lockout_reason(last_lockout_reason), .terminal_state(terminal_state));
  display_idle_timeout_menu #(.TICK_CYCLES(4), .TERMS(16)) dut_u (.mclk(mclk), .rst(rst),
    .btn_up_raw(btn[0]), .btn_down_raw(btn[1]), .btn_left_raw(btn[2]), .btn_right_raw(btn[3]),
    .btn_ok_raw(btn[4]), .lockout_active(lockout_active), .diag_active(diag_active),
    .main_valve_on(main_valve_on), .last_lockout_reason(last_lockout_reason), .terminal_state(terminal_state),
    .status_select(status_select), .lcd_on(lcd_on), .page(page), .menu_cursor(menu_cursor),
    .edit_value(edit_value), .focus_save(focus_save), .save_accept(save_accept), .sleep_setting(sleep_setting),
    .inact_setting(inact_setting), .status_line_item(status_line_item), .status_line_value(status_line_value),
    .status_line_terms(status_line_terms), .cycle_count(cycle_count), .hour_count(hour_count));
  // compare and count
  task chk(input [16:0] got, input [16:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      err_total = err_total + 1;
  end
  endtask
  // press, then settle to the falling edge
  task p(input integer b);
  begin
    pan.press(b);
    @(negedge mclk);
  end
  endtask
  // wait until page reaches a value, bounded
  task wait_page(input [4:0] want);
  begin
    n = 0;
    while (page !== want && n < 400)
    begin
      @(negedge mclk);
      n = n + 1;
    end
    if (page !== want)
      chk(page, want);
    if (page !== want)
      summarize;
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk(page, 5'h01);
    chk(save_accept, 1'b1);
    chk(lcd_on, 1'b1);
    p(ok);
    p(dn);
    chk(menu_cursor, 1'b1);
    p(ok);
    chk(page, 5'h08);
    chk(edit_value, 3'h0);
    p(up);
    chk(edit_value, 3'h1);
    p(rt);
    chk(focus_save, 1'b1);
    p(ok);
    chk(inact_setting, 3'h1);
    chk(page, 5'h02);
    wait_page(5'h01);
    chk(n > 100 && n < 126, 1'b1);
    $display("test inactivity done");
    @(posedge mclk);
    pan.diag_active <= 1'b1;
    p(ok);
    chk(menu_cursor, 1'b0);
    repeat (200) @(negedge mclk);
    chk(page, 5'h02);
    @(posedge mclk);
    pan.diag_active <= 1'b0;
    pan.lockout_active <= 1'b1;
    repeat (200) @(negedge mclk);
    chk(page, 5'h10);
    @(posedge mclk);
    pan.lockout_active <= 1'b0;
    wait_page(5'h01);
    $display("test exempt pages done");
    p(ok);
    chk(menu_cursor, 1'b0);
    p(ok);
    chk(page, 5'h04);
    chk(edit_value, 3'h0);
    p(dn);
    chk(edit_value, 3'h6);
    p(up);
    chk(edit_value, 3'h0);
    p(up);
    p(rt);
    chk(focus_save, 1'b1);
    p(dn);
    chk(save_accept, 1'b0);
    p(ok);
    chk(sleep_setting, 3'h0);
    chk(page, 5'h02);
    p(ok);
    p(up);
    p(rt);
    p(ok);
    chk(sleep_setting, 3'h1);
    chk(page, 5'h02);
    p(lt);
    n = 0;
    while (lcd_on === 1'b1 && n < 60)
    begin
      @(negedge mclk);
      n = n + 1;
    end
    chk(n > 7 && n < 21, 1'b1);
    if (lcd_on === 1'b1)
      summarize;
    p(ok);
    chk(lcd_on, 1'b1);
    chk(page, 5'h01);
    p(lt);
    p(up);
    p(dn);
    chk(lcd_on, 1'b1);
    chk(page, 5'h01);
    $display("test sleep done");
    @(posedge mclk);
    pan.last_lockout_reason <= 7'h55;
    pan.terminal_state <= 16'ha5c3;
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge mclk);
      pan.main_valve_on <= 1'b1;
      @(posedge mclk);
      pan.main_valve_on <= 1'b0;
    end
    for (i = 0; i < 5; i = i + 1)
    begin
      @(posedge mclk);
      status_select <= i[3:0];
      repeat (2) @(negedge mclk);
      chk(status_line_item, i[3:0]);
      chk(status_line_terms, i == 3 ? 16'ha5c3 : 16'h0);
      chk(status_line_value, i == 0 ? 17'h3 : i == 2 ? 17'h55 : 17'h0);
    end
    $display("test status line done");
    @(posedge mclk);
    status_select <= 4'h1;
    pan.main_valve_on <= 1'b1;
    repeat (14340) @(negedge mclk);
    chk(hour_count, 17'h0);
    repeat (80) @(negedge mclk);
    chk(hour_count, 17'h1);
    chk(status_line_value, 17'h1);
    chk(cycle_count, 17'h4);
    $display("test counters done");
    summarize;
  end
endmodule
